/* rtl/pmc_pkg.sv */
// constants shared by the power mode control block
package pmc_pkg;
	// =====================================================
	// register map
	localparam logic [3:0] PMC_ADDR_POWER_CONTROL = 4'h0;
	localparam logic [3:0] PMC_ADDR_STATUS        = 4'h1;
	localparam logic [7:0] PMC_POWER_CONTROL_RST  = 8'h00;
	localparam logic [7:0] PMC_WRITE_MASK         = 8'hDF;
	// =====================================================
	// field positions
	localparam int PMC_BIT_BAUD_DOUBLE  = 7;
	localparam int PMC_BIT_FRAME_ERR    = 6;
	localparam int PMC_BIT_RESERVED     = 5;
	localparam int PMC_BIT_POWER_ON     = 4;
	localparam int PMC_BIT_GENERAL_ONE  = 3;
	localparam int PMC_BIT_GENERAL_ZERO = 2;
	localparam int PMC_BIT_POWERDOWN    = 1;
	localparam int PMC_BIT_SLEEP        = 0;
	// =====================================================
	// timing
	localparam int PMC_CLK_MHZ             = 250;
	localparam int PMC_RESET_HOLD_CLOCKS   = 24;
	localparam int PMC_WAKE_COUNT_DEFAULT  = 32768;
	localparam int PMC_WAKE_CNT_W          = 16;
	localparam int PMC_RESET_CNT_W         = 5;
	// =====================================================
	// power state machine
	typedef enum logic [1:0]
	{
		PMC_RUN   = 2'b00,
		PMC_IDLE  = 2'b01,
		PMC_DOWN  = 2'b11,
		PMC_STABL = 2'b10
	} pmc_state_type;
endpackage : pmc_pkg

/* rtl/pmc_sync.sv */
// three-stage input synchroniser with agreement filter
module pmc_sync
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
)
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
	logic [WIDTH-1:0] out_d;

	always_comb
	begin
		out_d = out_q;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (s2_q[i] == s3_q[i])
			begin
				out_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q  <= INIT;
			s2_q  <= INIT;
			s3_q  <= INIT;
			out_q <= INIT;
		end
		else
		begin
			s1_q  <= async_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign sync_out = out_q;
endmodule // pmc_sync

/* rtl/pmc_wake_timer.sv */
// oscillator stabilisation counter after interrupt wake-up
module pmc_wake_timer
#(
	parameter int WAKE_COUNT = pmc_pkg::PMC_WAKE_COUNT_DEFAULT
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic start,
	output logic      done
);
	localparam logic [pmc_pkg::PMC_WAKE_CNT_W:0] LAST = (pmc_pkg::PMC_WAKE_CNT_W+1)'(WAKE_COUNT - 1);
	logic [pmc_pkg::PMC_WAKE_CNT_W:0] cnt_q, cnt_d;
	logic                             run_q, run_d;
	logic                             done_q, done_d;

	always_comb
	begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		done_d = 1'b0;
		if (start)
		begin
			cnt_d = '0;
			run_d = 1'b1;
		end
		else if (run_q)
		begin
			if (cnt_q == LAST)
			begin
				run_d  = 1'b0;
				done_d = 1'b1;
			end
			else
			begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q  <= '0;
			run_q  <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			run_q  <= run_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;
endmodule // pmc_wake_timer

/* rtl/pmc_power_mode_control.sv */
// power control register, idle and power-down sequencing
module pmc_power_mode_control
#(
	parameter int WAKE_COUNT = pmc_pkg::PMC_WAKE_COUNT_DEFAULT
)
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       power_on_event,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       instr_done,
	input  wire logic       irq_pending,
	input  wire logic       reset_pin,
	input  wire logic [3:0] ext_interrupt_pins,
	input  wire logic [3:0] ext_interrupt_enable,
	input  wire logic       rxd_pin,
	input  wire logic       rxd_wake_enable,
	input  wire logic       timer0_count_pin,
	input  wire logic       timer1_count_pin,
	input  wire logic [1:0] timer_wake_enable,
	output logic            cpu_clk_en,
	output logic            periph_clk_en,
	output logic            osc_enable,
	output logic            flash_enable,
	output logic            hold_state,
	output logic            strobe_force_high,
	output logic            internal_reset,
	output logic            restart_at_zero,
	output logic            baud_double,
	output logic            frame_error_select,
	output logic            wake_irq_pulse
);
	// =====================================================
	// synchronised pins
	logic       reset_s;
	logic [7:0] pins_s;
	logic [7:0] pins_prev_q;
	logic [7:0] pins_prev_d;

	pmc_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_rst
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (reset_pin),
		.sync_out (reset_s)
	);

	pmc_sync #(.WIDTH(8), .INIT(8'hFF)) u_sync_pins
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in ({timer1_count_pin, timer0_count_pin, rxd_pin, power_on_event, ext_interrupt_pins}),
		.sync_out (pins_s)
	);

	// =====================================================
	// wake source decode
	logic [7:0] wake_en;
	logic       wake_edge;
	logic       power_on_s;

	function automatic logic fall_hit(input logic [7:0] prev, input logic [7:0] cur, input logic [7:0] en);
		fall_hit = |(prev & ~cur & en);
	endfunction

	function automatic logic is_clocked(input pmc_pkg::pmc_state_type s);
		is_clocked = (s == pmc_pkg::PMC_RUN) || (s == pmc_pkg::PMC_IDLE);
	endfunction

	function automatic logic is_ctrl_addr(input logic [3:0] a);
		is_ctrl_addr = (a == pmc_pkg::PMC_ADDR_POWER_CONTROL);
	endfunction

	assign power_on_s = pins_s[4];
	assign wake_en    = {timer_wake_enable, rxd_wake_enable, 1'b0, ext_interrupt_enable};
	assign wake_edge  = fall_hit(pins_prev_q, pins_s, wake_en);

	// =====================================================
	// reset pin hold counter
	logic [pmc_pkg::PMC_RESET_CNT_W-1:0] rcnt_q, rcnt_d;
	logic                                pin_reset;
	logic                                pin_reset_q;
	logic                                power_on_q;
	logic                                power_on_d;

	always_comb
	begin
		pins_prev_d = pins_s;
		rcnt_d = rcnt_q;
		if (!reset_s)
		begin
			rcnt_d = '0;
		end
		else if (rcnt_q != pmc_pkg::PMC_RESET_CNT_W'(pmc_pkg::PMC_RESET_HOLD_CLOCKS))
		begin
			rcnt_d = rcnt_q + 1'b1;
		end
	end

	// 24 clock hold makes internal reset
	assign pin_reset  = (rcnt_q == pmc_pkg::PMC_RESET_CNT_W'(pmc_pkg::PMC_RESET_HOLD_CLOCKS));
	assign power_on_d = power_on_s;

	// edge history resets to idle levels, no false edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rcnt_q      <= '0;
			pin_reset_q <= 1'b0;
			power_on_q  <= 1'b1;
			pins_prev_q <= 8'hFF;
		end
		else
		begin
			rcnt_q      <= rcnt_d;
			pin_reset_q <= pin_reset;
			power_on_q  <= power_on_d;
			pins_prev_q <= pins_prev_d;
		end
	end

	// =====================================================
	// power control register and state machine
	logic [7:0]              power_control_q, power_control_d;
	pmc_pkg::pmc_state_type  state_q, state_d;
	logic                    timer_start;
	logic                    timer_done;
	logic                    wake_irq_d, wake_irq_q;
	logic                    zero_d, zero_q;
	logic [7:0]              rdata_d, rdata_q;

	always_comb
	begin
		power_control_d      = power_control_q;
		state_d     = state_q;
		timer_start = 1'b0;
		wake_irq_d  = 1'b0;
		zero_d      = 1'b0;
		if (power_on_s && !power_on_q)
		begin
			power_control_d[pmc_pkg::PMC_BIT_POWER_ON] = 1'b1;
		end
		if (reg_wr && is_ctrl_addr(reg_addr))
		begin
			// flags and controls writable; bit 5 ignored
			power_control_d = reg_wdata & pmc_pkg::PMC_WRITE_MASK;
			if (power_on_s && !power_on_q)
			begin
				power_control_d[pmc_pkg::PMC_BIT_POWER_ON] = 1'b1;
			end
		end
		case (state_q)
			pmc_pkg::PMC_RUN:
			begin
				if (instr_done && power_control_q[pmc_pkg::PMC_BIT_POWERDOWN])
				begin
					state_d = pmc_pkg::PMC_DOWN;
				end
				else if (instr_done && power_control_q[pmc_pkg::PMC_BIT_SLEEP])
				begin
					state_d = pmc_pkg::PMC_IDLE;
				end
			end
			pmc_pkg::PMC_IDLE:
			begin
				if (irq_pending)
				begin
					power_control_d[pmc_pkg::PMC_BIT_SLEEP] = 1'b0;
					state_d = pmc_pkg::PMC_RUN;
				end
			end
			pmc_pkg::PMC_DOWN:
			begin
				if (wake_edge)
				begin
					power_control_d[pmc_pkg::PMC_BIT_POWERDOWN] = 1'b0;
					timer_start = 1'b1;
					state_d = pmc_pkg::PMC_STABL;
				end
			end
			default:
			begin
				if (timer_done)
				begin
					wake_irq_d = 1'b1;
					state_d = pmc_pkg::PMC_RUN;
				end
			end
		endcase
		// reset pin overrides every mode; restart at zero
		if (pin_reset)
		begin
			zero_d  = (state_q == pmc_pkg::PMC_DOWN) || (state_q == pmc_pkg::PMC_STABL) || !pin_reset_q;
			state_d = pmc_pkg::PMC_RUN;
			power_control_d  = (power_control_d & (8'h01 << pmc_pkg::PMC_BIT_POWER_ON));
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			power_control_q      <= pmc_pkg::PMC_POWER_CONTROL_RST;
			state_q     <= pmc_pkg::PMC_RUN;
			wake_irq_q  <= 1'b0;
			zero_q      <= 1'b0;
		end
		else
		begin
			power_control_q      <= power_control_d;
			state_q     <= state_d;
			wake_irq_q  <= wake_irq_d;
			zero_q      <= zero_d;
		end
	end

	// =====================================================
	// register read port
	always_comb
	begin
		rdata_d = 8'h00;
		if (reg_rd && is_ctrl_addr(reg_addr))
		begin
			rdata_d = power_control_q;
		end
		else if (reg_rd && reg_addr == pmc_pkg::PMC_ADDR_STATUS)
		begin
			rdata_d = {6'h00, state_q};
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_q <= 8'h00;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	pmc_wake_timer #(.WAKE_COUNT(WAKE_COUNT)) u_wake_timer
	(
		.clk   (clk),
		.rst_n (rst_n),
		.start (timer_start),
		.done  (timer_done)
	);

	// =====================================================
	// outputs
	// CPU clock gated outside run
	assign cpu_clk_en         = (state_q == pmc_pkg::PMC_RUN);
	assign periph_clk_en      = is_clocked(state_q);
	// oscillator and flash stop in power-down
	assign osc_enable         = (state_q != pmc_pkg::PMC_DOWN);
	assign flash_enable       = is_clocked(state_q);
	// hold CPU and pins, strobes high
	assign hold_state         = (state_q != pmc_pkg::PMC_RUN);
	assign strobe_force_high  = (state_q == pmc_pkg::PMC_IDLE);
	assign internal_reset     = pin_reset;
	assign restart_at_zero    = zero_q;
	assign baud_double        = power_control_q[pmc_pkg::PMC_BIT_BAUD_DOUBLE];
	assign frame_error_select = power_control_q[pmc_pkg::PMC_BIT_FRAME_ERR];
	assign wake_irq_pulse     = wake_irq_q;
	assign reg_rdata          = rdata_q;
endmodule // pmc_power_mode_control

/* verification/pmc_power_mode_control_asserts.sv */
// port checker for the power mode control block
module pmc_checker
#(
	parameter int WAKE_COUNT = 8
)
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       irq_pending,
	input wire logic       reset_pin,
	input wire logic       cpu_clk_en,
	input wire logic       periph_clk_en,
	input wire logic       osc_enable,
	input wire logic       flash_enable,
	input wire logic       hold_state,
	input wire logic       strobe_force_high,
	input wire logic       internal_reset,
	input wire logic       baud_double,
	input wire logic       frame_error_select
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic [15:0] stab_q;
	logic [15:0] stab_d;
	// =====================================
	// stabilisation cycle count
	always_comb
	begin
		stab_d = stab_q;
		if (!osc_enable)
			stab_d = '0;
		else if (!periph_clk_en && stab_q != 16'hFFFF)
			stab_d = stab_q + 16'h0001;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stab_q <= '0;
		else
			stab_q <= stab_d;
	end
	// =====================================
	// assertions
	run_clocks_a: assert property (cpu_clk_en |-> periph_clk_en && osc_enable && flash_enable && !hold_state)
		else $error("clock enables wrong while running");
	idle_hold_a: assert property (strobe_force_high |-> !cpu_clk_en && periph_clk_en && hold_state)
		else $error("idle outputs wrong");
	down_stop_a: assert property (!osc_enable |-> !flash_enable && !periph_clk_en && !cpu_clk_en)
		else $error("power-down outputs wrong");
	idle_wake_a: assert property (strobe_force_high && irq_pending && !reset_pin |=> cpu_clk_en)
		else $error("idle not left on interrupt");
	reset_len_a: assert property ($rose(internal_reset) |-> $past(reset_pin, 24))
		else $error("internal reset too early");
	reset_run_a: assert property (internal_reset |=> cpu_clk_en)
		else $error("reset did not restore running");
	baud_wr_a: assert property (reg_wr && reg_addr == 4'h0 && !internal_reset |=> baud_double == $past(reg_wdata[7]))
		else $error("baud double not following write");
	frame_wr_a: assert property (reg_wr && reg_addr == 4'h0 && !internal_reset
		|=> frame_error_select == $past(reg_wdata[6]))
		else $error("frame error select not following write");
	rsvd_read_a: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[5] == 1'b0)
		else $error("reserved bit read as one");
	wake_count_a: assert property ($rose(cpu_clk_en) && !$past(periph_clk_en) && !$past(internal_reset)
		|-> stab_q >= WAKE_COUNT - 1)
		else $error("wake before stabilisation count");
	cover property (strobe_force_high);
	cover property (!osc_enable);
	cover property (!periph_clk_en && osc_enable);
endmodule // pmc_checker

bind pmc_power_mode_control pmc_checker #(.WAKE_COUNT(WAKE_COUNT)) u_chk (.*);

/* verification/pmc_wake_model.sv */
// wake-up and reset pin sources outside the block
module pmc_wake_model
#(
	parameter int HOLD = 40
)
(
	input  wire logic clk,
	input  wire logic cpu_clk_en,
	output logic      reset_pin,
	output logic [3:0] ext_interrupt_pins,
	output logic      rxd_pin,
	output logic      timer0_count_pin,
	output logic      timer1_count_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] pin_q = 7'h7F;
	initial reset_pin = 1'b0;
	assign {timer1_count_pin, timer0_count_pin, rxd_pin, ext_interrupt_pins} = pin_q;
	task automatic wake(input int idx);
		@(posedge clk);
		pin_q[idx] <= 1'b0;
		repeat (6) @(posedge clk);
		for (int n = 0; n < 200 && cpu_clk_en !== 1'b1; n++)
			@(posedge clk);
		pin_q[idx] <= 1'b1;
	endtask
	task automatic reset_hold;
		@(posedge clk);
		reset_pin <= 1'b1;
		repeat (HOLD) @(posedge clk);
		reset_pin <= 1'b0;
		repeat (10) @(posedge clk);
	endtask
endmodule // pmc_wake_model

/* verification/tb.sv */
// self-checking bench for the power mode control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] wd; logic [7:0] ex;} pmc_row_type;
	pmc_row_type rows [4] = '{'{8'hFF, 8'hDF}, '{8'h20, 8'h00}, '{8'h8C, 8'h8C}, '{8'h40, 8'h40}};
	logic clk = 1'b0;
	logic rst_n, power_on_event, reg_wr, reg_rd, instr_done, irq_pending, reset_pin;
	logic rxd_pin, timer0_count_pin, timer1_count_pin, rxd_wake_enable, cpu_clk_en, periph_clk_en;
	logic osc_enable, flash_enable, hold_state, strobe_force_high, internal_reset, restart_at_zero;
	logic baud_double, frame_error_select, wake_irq_pulse;
	logic [1:0] timer_wake_enable;
	logic [3:0] reg_addr, ext_interrupt_pins, ext_interrupt_enable;
	logic [7:0] reg_wdata, reg_rdata, rd_q;
	logic [6:0] wen;
	int miscompares = 0;
	int tests_run = 0;
	int wakes = 0;
	int zeros = 0;
	int z0;
	assign {timer_wake_enable, rxd_wake_enable, ext_interrupt_enable} = wen;
	always #2 clk = ~clk;
	always @(posedge clk) wakes <= wakes + int'(wake_irq_pulse === 1'b1);
	always @(posedge clk) zeros <= zeros + int'(restart_at_zero === 1'b1);
	pmc_power_mode_control #(.WAKE_COUNT(8)) u_dut (.*);
	pmc_wake_model #(.HOLD(40)) u_src (.*);
	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		tests_run++;
		if (got !== ex)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		rd_q = reg_rdata;
	endtask
	task automatic go(input logic [7:0] v);
		repeat (1000) @(posedge clk);
		wr(4'h0, v);
		@(posedge clk);
		instr_done <= 1'b1;
		@(posedge clk);
		instr_done <= 1'b0;
		@(negedge clk);
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#200000;
		miscompares++;
		tally_and_finish;
	end
	initial
	begin
		{rst_n, power_on_event, reg_wr, reg_rd, instr_done, irq_pending, reg_addr, reg_wdata, wen} = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i])
		begin
			wr(4'h0, rows[i].wd);
			rd(4'h0);
			chk("power_control", rows[i].ex, rd_q);
			chk("baud_double", {7'h00, rows[i].ex[7]}, {7'h00, baud_double});
			chk("frame_error_select", {7'h00, rows[i].ex[6]}, {7'h00, frame_error_select});
		end
		power_on_event <= 1'b1;
		repeat (6) @(posedge clk);
		rd(4'h0);
		chk("power_on_flag_set", 8'h50, rd_q);
		wr(4'h0, 8'h00);
		rd(4'h0);
		chk("power_on_flag_clear", 8'h00, rd_q);
		rd(4'h7);
		chk("unmapped", 8'h00, rd_q);
		go(8'h05);
		chk("idle_enables", 8'h03, {5'h00, cpu_clk_en, periph_clk_en, strobe_force_high});
		@(posedge clk);
		irq_pending <= 1'b1;
		@(posedge clk);
		irq_pending <= 1'b0;
		rd(4'h0);
		chk("idle_cleared", 8'h04, rd_q);
		for (int i = 0; i < 7; i++)
		begin
			wen <= 7'(1 << i);
			go(i == 0 ? 8'h03 : 8'h02);
			rd(4'h1);
			chk("status_down", 8'h03, rd_q);
			chk("down_enables", 8'h00, {6'h00, osc_enable, flash_enable});
			u_src.wake(i);
			wen <= 7'h00;
			@(posedge clk);
		end
		chk("wake_pulses", 8'h07, wakes[7:0]);
		go(8'h02);
		u_src.wake(4);
		rd(4'h1);
		chk("disabled_source", 8'h03, rd_q);
		z0 = zeros;
		u_src.reset_hold();
		chk("restart_at_zero", 8'h01, 8'(zeros - z0));
		go(8'h01);
		u_src.reset_hold();
		rd(4'h1);
		chk("status_after_reset", 8'h00, rd_q);
		rd(4'h0);
		chk("reg_after_reset", 8'h00, rd_q);
		tally_and_finish;
	end
endmodule // tb
